// [hw/crcfd_top.sv]
// CRC engine with byte buffer feed and transfer channel 3 RAM feed
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module crcfd_top
  import crcfd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Transfer channel 3 RAM read port
  output logic ram_req,
  output logic [15:0] ram_addr,
  input wire logic [7:0] ram_rdata,
  input wire logic ram_ack,
  // Channel 3 arbiter controls
  output logic channel3_wait_disable,
  output logic channel3_bus_steal_disable
);

  // Bit-serial LFSR over one byte, top term implied by the shift-out
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d,
                                           input logic [15:0] p,
                                           input logic msb);
    logic [15:0] r;
    logic b;
    r = c;
    b = 1'b0;
    for (int i = 0; i < 8; i++) begin
      b = msb ? d[7-i] : d[i];
      if (r[15] ^ b) begin
        r = (r << 1) ^ p;
      end else begin
        r = r << 1;
      end
    end
    return r;
  endfunction

  // State
  logic [7:0] inbuf_q, inbuf_d;
  logic run_q, run_d, auto_q, auto_d, dir_q, dir_d;
  logic win_q, win_d, end_q, end_d, ie_q, ie_d;
  logic [15:0] crc_q, crc_d, poly_q, poly_d;
  logic [7:0] adrl_q, adrl_d, ctr_q, ctr_d, tst_q, tst_d;
  logic [6:0] adrh_q, adrh_d;
  logic [WS_BITS-1:0] wsc_q, wsc_d;
  logic [EVT_BITS-1:0] evt_q, evt_d, mask_q, mask_d;
  crcfd_state_e state_q, state_d;
  logic [12:0] cnt_q, cnt_d;
  logic [15:0] addr_q, addr_d;
  logic [31:0] prdata_q, prdata_d;
  logic done;

  // Bus decode; registers sit on word-aligned addresses only
  logic acc, wr, rd, setup, aligned, mapped;
  logic [14:0] idx;
  logic [15:0] base;
  logic [12:0] total;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign setup = psel & ~penable;
  assign idx = paddr[APB_AW-1:2];
  assign aligned = (paddr[1:0] == 2'b00);

  always_comb begin
    case (idx)
      IDX_INPUT_BYTE, IDX_CTRL_STAT, IDX_WIN_LOW, IDX_WIN_HIGH,
      IDX_CH3_BASE_LOW, IDX_CH3_BASE_HIGH, IDX_CH3_COUNT_LOW,
      IDX_XFER_TEST, IDX_XFER_WS_CTRL, IDX_EVT_STATUS,
      IDX_EVT_MASK: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  // Channel 3 RAM base and byte-mode transfer count
  assign base = {1'b0, adrh_q, adrl_q[7:4], 4'h0};
  assign total = 13'({adrl_q[3:0], ctr_q}) + CNT_EXTRA;

  // Zero-wait slave; unmapped or unaligned access flags an error
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  // Level interrupt: documented enable pair or any unmasked event
  assign irq = (ie_q & end_q) | (|(evt_q & mask_q));

  assign ram_req = (state_q == CRCFD_FETCH) & run_q;
  assign ram_addr = addr_q;
  assign channel3_wait_disable = wsc_q[WS_WAIT3];
  assign channel3_bus_steal_disable = wsc_q[WS_STEAL3];

  // Next state of registers and engine
  always_comb begin
    inbuf_d = inbuf_q;
    run_d = run_q;
    auto_d = auto_q;
    dir_d = dir_q;
    win_d = win_q;
    end_d = end_q;
    ie_d = ie_q;
    crc_d = crc_q;
    poly_d = poly_q;
    adrl_d = adrl_q;
    adrh_d = adrh_q;
    ctr_d = ctr_q;
    tst_d = tst_q;
    wsc_d = wsc_q;
    evt_d = evt_q;
    mask_d = mask_q;
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    done = 1'b0;
    // Read clears only the bits that the read returned
    if (rd && aligned && idx == IDX_EVT_STATUS) begin
      evt_d = evt_q & ~prdata_q[EVT_BITS-1:0];
    end
    if (wr && aligned) begin
      case (idx)
        IDX_INPUT_BYTE: inbuf_d = pwdata[7:0];
        IDX_CTRL_STAT: begin
          run_d = pwdata[CTL_RUN];
          auto_d = pwdata[CTL_AUTO];
          dir_d = pwdata[CTL_DIR];
          win_d = pwdata[CTL_WIN];
          end_d = end_q & pwdata[CTL_END];
          ie_d = pwdata[CTL_IE];
        end
        IDX_WIN_LOW: begin
          // Shared address: software picks the window first
          if (win_q) begin
            poly_d[7:0] = pwdata[7:0];
          end else begin
            crc_d[7:0] = pwdata[7:0];
          end
        end
        IDX_WIN_HIGH: begin
          if (win_q) begin
            poly_d[15:8] = pwdata[7:0];
          end else begin
            crc_d[15:8] = pwdata[7:0];
          end
        end
        // Base is not guarded against change while running
        IDX_CH3_BASE_LOW: adrl_d = pwdata[7:0];
        IDX_CH3_BASE_HIGH: adrh_d = pwdata[6:0];
        IDX_CH3_COUNT_LOW: ctr_d = pwdata[7:0];
        IDX_XFER_TEST: tst_d = pwdata[7:0];
        IDX_XFER_WS_CTRL: wsc_d = pwdata[WS_BITS-1:0];
        IDX_EVT_MASK: mask_d = pwdata[EVT_BITS-1:0];
        default: ;
      endcase
    end
    // Engine last, so completion wins over a same-cycle write
    case (state_q)
      CRCFD_IDLE: begin
        if (run_q) begin
          if (auto_q) begin
            state_d = CRCFD_FETCH;
            cnt_d = 13'h0000;
            addr_d = base;
          end else begin
            crc_d = crc_byte(crc_q, inbuf_q, poly_q, dir_q);
            done = 1'b1;
          end
        end
      end
      CRCFD_FETCH: begin
        if (!run_q) begin
          // Software abort: drop out without completion
          state_d = CRCFD_IDLE;
        end else if (ram_ack) begin
          crc_d = crc_byte(crc_q, ram_rdata, poly_q, dir_q);
          cnt_d = cnt_q + 13'h0001;
          addr_d = addr_q + 16'h0001;
          evt_d[EVT_BYTE] = 1'b1;
          if (cnt_q + 13'h0001 == total) begin
            state_d = CRCFD_IDLE;
            done = 1'b1;
          end
        end
      end
      default: state_d = CRCFD_IDLE;
    endcase
    if (done) begin
      run_d = 1'b0;
      end_d = 1'b1;
      evt_d[EVT_DONE] = 1'b1;
    end
  end

  // Register stage for all state but the read data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      inbuf_q <= RST_BYTE;
      run_q <= 1'b0;
      auto_q <= 1'b0;
      dir_q <= 1'b0;
      win_q <= 1'b0;
      end_q <= 1'b0;
      ie_q <= 1'b0;
      crc_q <= RST_WORD;
      poly_q <= RST_WORD;
      adrl_q <= RST_BYTE;
      adrh_q <= 7'h00;
      ctr_q <= RST_BYTE;
      tst_q <= RST_BYTE;
      wsc_q <= '0;
      evt_q <= '0;
      mask_q <= '0;
      state_q <= CRCFD_IDLE;
      cnt_q <= 13'h0000;
      addr_q <= RST_WORD;
    end else begin
      inbuf_q <= inbuf_d;
      run_q <= run_d;
      auto_q <= auto_d;
      dir_q <= dir_d;
      win_q <= win_d;
      end_q <= end_d;
      ie_q <= ie_d;
      crc_q <= crc_d;
      poly_q <= poly_d;
      adrl_q <= adrl_d;
      adrh_q <= adrh_d;
      ctr_q <= ctr_d;
      tst_q <= tst_d;
      wsc_q <= wsc_d;
      evt_q <= evt_d;
      mask_q <= mask_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
    end
  end

  // Read data picked in the setup cycle, held through the access
  always_comb begin
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (aligned) begin
        case (idx)
          IDX_INPUT_BYTE: prdata_d[7:0] = inbuf_q;
          IDX_CTRL_STAT: prdata_d[5:0] = {run_q, auto_q, dir_q, win_q,
                                          end_q, ie_q};
          IDX_WIN_LOW: prdata_d[7:0] = win_q ? poly_q[7:0] : crc_q[7:0];
          IDX_WIN_HIGH: prdata_d[7:0] = win_q ? poly_q[15:8] : crc_q[15:8];
          IDX_CH3_BASE_LOW: prdata_d[7:0] = adrl_q;
          IDX_CH3_BASE_HIGH: prdata_d[6:0] = adrh_q;
          IDX_CH3_COUNT_LOW: prdata_d[7:0] = ctr_q;
          IDX_XFER_TEST: prdata_d[7:0] = tst_q;
          IDX_XFER_WS_CTRL: prdata_d[WS_BITS-1:0] = wsc_q;
          IDX_EVT_STATUS: prdata_d[EVT_BITS-1:0] = evt_q;
          IDX_EVT_MASK: prdata_d[EVT_BITS-1:0] = mask_q;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_mode0_start;
    $rose(run_q) && !auto_q && state_q == CRCFD_IDLE;
  endsequence

  sequence s_last_byte;
    state_q == CRCFD_FETCH && run_q && ram_ack && cnt_q + 13'h0001 == total;
  endsequence

  sequence s_finished;
    !run_q && end_q && state_q == CRCFD_IDLE;
  endsequence

  a_mode0_finish: assert property (s_mode0_start |=> s_finished)
    else $error("mode 0 byte did not finish in one cycle");

  a_mode0_crc: assert property (s_mode0_start |=> crc_q ==
    crc_byte($past(crc_q), $past(inbuf_q), $past(poly_q), $past(dir_q)))
    else $error("mode 0 remainder wrong");

  // Unmasked events may raise the line too, even with the enable off
  a_mode1_done: assert property (s_last_byte |=> s_finished ##0
    irq == (ie_q || (|(evt_q & mask_q))))
    else $error("mode 1 did not complete on last byte");

  a_count_step: assert property (
    state_q == CRCFD_FETCH && run_q && ram_ack
    |=> cnt_q == $past(cnt_q) + 13'h0001 && addr_q == $past(addr_q) + 16'h1)
    else $error("channel 3 count did not advance by one");

  a_fetch_addr: assert property (
    ram_req |-> ram_addr == base + 16'(cnt_q))
    else $error("RAM address off base plus count");

  a_end_sticky: assert property (end_q && !(wr && aligned &&
    idx == IDX_CTRL_STAT && !pwdata[CTL_END]) |=> end_q)
    else $error("completion flag lost without a clear");

  a_irq_level: assert property (ie_q && end_q |-> irq)
    else $error("interrupt missing while enabled flag set");

  a_window_read: assert property (setup && aligned && idx == IDX_WIN_LOW
    |=> prdata == {24'h0, $past(win_q) ? $past(poly_q[7:0])
                                     : $past(crc_q[7:0])})
    else $error("shared window returned wrong register");

  a_wait_write: assert property (
    wr && aligned && idx == IDX_XFER_WS_CTRL
    |=> channel3_wait_disable == $past(pwdata[WS_WAIT3]) &&
        channel3_bus_steal_disable == $past(pwdata[WS_STEAL3]))
    else $error("channel 3 disable bits not taken");

endmodule

`default_nettype wire

// [inc/crcfd_pkg.sv]
// Constants, register indices and states of the CRC engine with transfer feed
package crcfd_pkg;

  // APB address width; byte address is four times the register index
  localparam int unsigned APB_AW = 17;

  // Register indices (byte address = index * 4)
  localparam logic [14:0] IDX_INPUT_BYTE = 15'h7fb8;
  localparam logic [14:0] IDX_CTRL_STAT = 15'h7fb9;
  localparam logic [14:0] IDX_WIN_LOW = 15'h7fba;
  localparam logic [14:0] IDX_WIN_HIGH = 15'h7fbb;
  localparam logic [14:0] IDX_CH3_BASE_LOW = 15'h7fe6;
  localparam logic [14:0] IDX_CH3_BASE_HIGH = 15'h7fe7;
  localparam logic [14:0] IDX_CH3_COUNT_LOW = 15'h7fec;
  localparam logic [14:0] IDX_XFER_TEST = 15'h7ffe;
  localparam logic [14:0] IDX_XFER_WS_CTRL = 15'h7fff;
  localparam logic [14:0] IDX_EVT_STATUS = 15'h7fc0;
  localparam logic [14:0] IDX_EVT_MASK = 15'h7fc1;

  // Control and status field positions
  localparam int unsigned CTL_RUN = 5;
  localparam int unsigned CTL_AUTO = 4;
  localparam int unsigned CTL_DIR = 3;
  localparam int unsigned CTL_WIN = 2;
  localparam int unsigned CTL_END = 1;
  localparam int unsigned CTL_IE = 0;

  // Transfer wait / bus steal control fields for channel 3
  localparam int unsigned WS_WAIT3 = 1;
  localparam int unsigned WS_STEAL3 = 0;
  localparam int unsigned WS_BITS = 6;

  // Event status bits
  localparam int unsigned EVT_DONE = 0;
  localparam int unsigned EVT_BYTE = 1;
  localparam int unsigned EVT_BITS = 2;

  // Reset values and byte-mode count offset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [12:0] CNT_EXTRA = 13'h0002;

  // Engine states
  typedef enum logic {CRCFD_IDLE, CRCFD_FETCH} crcfd_state_e;

endpackage

// [testbench/crcfd_ram_model.sv]
// RAM responder standing behind the channel 3 read port
`timescale 1ns/1ps
`default_nettype none

module crcfd_ram_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Read port
  input wire logic ram_req,
  input wire logic [15:0] ram_addr,
  output logic [7:0] ram_rdata,
  output logic ram_ack,
  // Answer delay in cycles
  input wire logic [1:0] lat
);
  logic [1:0] wait_q;

  // One-cycle ack per request; data toggles when not valid
  always_ff @(posedge core_clk) begin
    if (rst || !ram_req || ram_ack) begin
      ram_ack <= 1'b0;
      wait_q <= lat;
      ram_rdata <= rst ? 8'h00 : ~ram_rdata;
    end else if (wait_q != 2'd0) begin
      wait_q <= wait_q - 2'd1;
      ram_rdata <= ~ram_rdata;
    end else begin
      ram_ack <= 1'b1;
      ram_rdata <= ram_addr[7:0] ^ 8'h5a; // Address-derived pattern
    end
  end
endmodule

`default_nettype wire

// [testbench/tb_crcfd_top.sv]
// Self-checking bench for the CRC engine with transfer feed
`timescale 1ns/1ps
`default_nettype none

module tb_crcfd_top
  import crcfd_pkg::*;
;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic ram_req, ram_ack, wdis, sdis;
  logic [1:0] lat;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] ram_addr, crc;
  // Expected next RAM address; only the monitor moves it
  logic [15:0] nxt_addr = 16'h0130;
  logic [7:0] ram_rdata, b, c;
  logic [32:0] exp_q[$];
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int acks = 0;
  int seed;
  localparam logic [14:0] RIDX[11] = '{IDX_INPUT_BYTE, IDX_CTRL_STAT,
    IDX_WIN_LOW, IDX_WIN_HIGH, IDX_CH3_BASE_LOW, IDX_CH3_BASE_HIGH,
    IDX_CH3_COUNT_LOW, IDX_XFER_TEST, IDX_XFER_WS_CTRL, IDX_EVT_STATUS,
    IDX_EVT_MASK};

  crcfd_top uut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .ram_req(ram_req), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .ram_ack(ram_ack), .channel3_wait_disable(wdis),
    .channel3_bus_steal_disable(sdis));

  crcfd_ram_model ram (.core_clk(core_clk), .rst(rst), .ram_req(ram_req),
    .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_ack(ram_ack),
    .lat(lat));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [32:0] e,
      input logic [32:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One compare task per kind of result
  task automatic cmp_read(input logic [32:0] e, input logic [32:0] s);
    cmp("read", e, s);
  endtask

  task automatic cmp_irq(input logic e);
    cmp("irq", {32'h0, e}, {32'h0, irq});
  endtask

  task automatic cmp_addr(input logic [15:0] e);
    cmp("ram_addr", {17'h0, e}, {17'h0, ram_addr});
  endtask

  task automatic cmp_acks(input int e);
    cmp("acks", {1'b0, e}, {1'b0, acks});
  endtask

  task automatic cmp_disables(input logic [1:0] e);
    cmp("disables", {31'h0, e}, {31'h0, wdis, sdis});
  endtask

  // One APB transfer; a read notes {pslverr, prdata} expected
  task automatic apb(input logic wr, input logic [14:0] idx,
      input logic [7:0] wd, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    if (!wr) exp_q.push_back(e);
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Bit-serial reference, polynomial 1021 with the top term implied
  function automatic logic [15:0] step(input logic [15:0] s,
      input logic [7:0] d, input logic msb);
    logic x;
    for (int i = 0; i < 8; i++) begin
      x = s[15] ^ (msb ? d[7-i] : d[i]);
      s = {s[14:0], 1'b0} ^ (x ? 16'h1021 : 16'h0000);
    end
    return s;
  endfunction

  // Read data and channel 3 addresses checked as they appear
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite)
      cmp_read(exp_q.pop_front(), {pslverr, prdata});
    if (ram_ack && ram_req) begin
      cmp_addr(nxt_addr);
      nxt_addr <= nxt_addr + 16'h0001;
      acks <= acks + 1;
    end
  end

  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    seed = 32'h762e1878;
    {psel, penable, pwrite, paddr, pwdata, lat} = '0;
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // Reset values, then an unmapped place
    foreach (RIDX[i]) apb(1'b0, RIDX[i], '0, 33'h0);
    apb(1'b0, 15'h0100, '0, {1'b1, 32'h0});
    // Polynomial through window 1, start value through window 0
    apb(1'b1, IDX_CTRL_STAT, 8'h04, '0);
    apb(1'b1, IDX_WIN_LOW, 8'h21, '0);
    apb(1'b1, IDX_WIN_HIGH, 8'h10, '0);
    apb(1'b0, IDX_WIN_LOW, '0, 33'h21);
    apb(1'b1, IDX_CTRL_STAT, 8'h00, '0);
    apb(1'b1, IDX_WIN_LOW, 8'hff, '0);
    apb(1'b1, IDX_WIN_HIGH, 8'hff, '0);
    apb(1'b0, IDX_WIN_HIGH, '0, 33'hff);
    crc = 16'hffff;
    // Buffer bytes, LSB first with enable, MSB first with event mask
    for (int d = 0; d < 2; d++) begin
      b = 8'($random(seed));
      c = 8'h20 | {4'h0, d[0], 3'h0} | {7'h0, ~d[0]};
      crc = step(crc, b, d[0]);
      apb(1'b1, IDX_EVT_MASK, {7'h0, d[0]}, '0);
      apb(1'b1, IDX_INPUT_BYTE, b, '0);
      apb(1'b0, IDX_INPUT_BYTE, '0, {25'h0, b});
      apb(1'b1, IDX_CTRL_STAT, c, '0);
      repeat (2) @(posedge core_clk);
      cmp_irq(1'b1);
      apb(1'b0, IDX_WIN_LOW, '0, {25'h0, crc[7:0]});
      apb(1'b0, IDX_WIN_HIGH, '0, {25'h0, crc[15:8]});
      apb(1'b0, IDX_CTRL_STAT, '0, {25'h0, c ^ 8'h22});
      apb(1'b1, IDX_CTRL_STAT, {4'h0, d[0], 3'h0}, '0);
      apb(1'b0, IDX_EVT_STATUS, '0, 33'h1);
      cmp_irq(1'b0);
    end
    // Channel 3 feeds three RAM bytes, answered slowly or promptly
    lat <= 2'($random(seed));
    // Base set only while the channel is stopped
    apb(1'b1, IDX_CH3_BASE_LOW, 8'h30, '0);
    apb(1'b1, IDX_CH3_BASE_HIGH, 8'h01, '0);
    apb(1'b1, IDX_CH3_COUNT_LOW, 8'h01, '0);
    apb(1'b1, IDX_CTRL_STAT, 8'h39, '0);
    for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge core_clk);
    @(posedge core_clk);
    for (int i = 0; i < 3; i++) crc = step(crc, 8'h30 + i[7:0] ^ 8'h5a, 1'b1);
    cmp_acks(3);
    apb(1'b0, IDX_WIN_LOW, '0, {25'h0, crc[7:0]});
    apb(1'b0, IDX_WIN_HIGH, '0, {25'h0, crc[15:8]});
    apb(1'b0, IDX_CTRL_STAT, '0, 33'h1b);
    apb(1'b0, IDX_EVT_STATUS, '0, 33'h03);
    // Channel 3 wait and bus steal disables, every combination
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, IDX_XFER_WS_CTRL, v[7:0], '0);
      cmp_disables(v[1:0]);
    end
    apb(1'b1, IDX_XFER_TEST, 8'h00, '0);
    print_verdict();
  end
endmodule

`default_nettype wire
